/* core/csi_chan_pkg.sv */
// Register map, field layout, types and helper functions of the serial channel.
package csi_chan_pkg;

  // ==========================================================
  // Register word indices (byte address is four times the index)
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_CLKDIV = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_CONTROL = 3'h4;

  // ==========================================================
  // Field positions
  localparam int ST_BUSY = 0;
  localparam int ST_BUF_FULL = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_OVERRUN = 3;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_ENABLED = 0;
  localparam int SEL_LOW = 0;
  localparam int SEL_HIGH = 1;

  // ==========================================================
  // Widths and reset values
  localparam int MODE_W = 6;
  localparam int RATE_W = 11;
  localparam int DIV_CNT_W = 22;
  localparam logic [3:0] FRAME_LEN8 = 4'h8;
  localparam logic [3:0] FRAME_LEN7 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
  localparam logic [RATE_W-1:0] RATE_RESET = 11'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic len7;
    logic lsbFirst;
    logic clock_polarity_sel;
    logic data_phase_sel;
    logic txRx;
    logic interrupt_timing_sel;
  } cfg_t;

  typedef struct packed {
    logic [6:0] divider;
    logic [3:0] prescale;
  } rate_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_LOW = 4'b0100,
    ST_HIGH = 4'b1000
  } state_t;

  // ==========================================================
  // Decoders
  function automatic logic [3:0] frameLen(input cfg_t c);
    frameLen = c.len7 ? FRAME_LEN7 : FRAME_LEN8;
  endfunction

  function automatic logic headBit(input logic [7:0] sh, input cfg_t c);
    if (c.lsbFirst) begin
      headBit = sh[0];
    end else begin
      headBit = c.len7 ? sh[6] : sh[7];
    end
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic b, input cfg_t c);
    if (!c.lsbFirst) begin
      shiftIn = {sh[6:0], b};
    end else begin
      shiftIn = c.len7 ? {1'b0, b, sh[6:1]} : {b, sh[7:1]};
    end
  endfunction

endpackage

/* core/csi_rate_divider.sv */
// Half-period strobe generator for the serial clock.
`timescale 1ns/10ps

module csi_rate_divider
  import csi_chan_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire rate_t rate,
  // Strobe
  output logic tick
);

  logic [DIV_CNT_W-1:0] count;
  logic [DIV_CNT_W-1:0] next_count;
  logic [DIV_CNT_W-1:0] last;
  logic next_tick;

  // ==========================================================
  // Half period is (divider+1) << prescale clocks, at least one clock.
  // At the largest setting the shift wraps to zero, so last becomes all ones,
  // which is exactly 2^22 - 1.
  always_comb begin
    last = (DIV_CNT_W'(rate.divider) + DIV_CNT_W'(1)) << rate.prescale;
    last = last - DIV_CNT_W'(1);
    next_tick = run && (count == last);
    next_count = (!run || count == last) ? '0 : count + DIV_CNT_W'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule

/* core/csi_master_receive_duplex.sv */
// Clocked serial channel, master reception and master transmit/receive.
`timescale 1ns/10ps

// Summary of operation
// - Receive-only mode drives the serial clock and samples input, output pin undriven.
// - Transmit/receive mode shifts out and in at the same time under own clock.
// - One interrupt, at frame end or at buffer empty, chosen by software.
// - Only error indication is the overrun flag; no parity or framing checks.
// - Frames are seven or eight bits long.
// - Serial clock never runs faster than half the operation clock.
// - Slowest serial clock is clock divided by two, two to fifteen, and 128.
// - Data phase cleared: output data starts with the serial clock activity.
// - Data phase set: data starts half a serial clock before clock toggles.
// - Data phase moves output and input together in transmit/receive mode.
// - Polarity zero gives forward clocking, one gives inverted clocking.
// - Interrupt timing may change mid-transfer without disturbing the transfer.
// - Writing transmit data while the buffer is full replaces the held data.
// - Clearing interrupt timing moves the interrupt to frame-end timing.
module csi_master_receive_duplex
  import csi_chan_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  output logic serialClockPin,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutEnable,
  // Interrupt request, one clock per event
  output logic channelInterrupt
);

  // ==========================================================
  // Bus decode
  logic req;
  logic wrReq;
  logic wrMode;
  logic wrRateLow;
  logic wrRateHigh;
  logic wrData;
  logic rdData;
  logic wrStatus;
  logic wrCtrl;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wrReq = req & we_i;
  assign wrMode = wrReq & sel_i[SEL_LOW] & (adr_i == REG_MODE);
  assign wrRateLow = wrReq & sel_i[SEL_LOW] & (adr_i == REG_CLKDIV);
  assign wrRateHigh = wrReq & sel_i[SEL_HIGH] & (adr_i == REG_CLKDIV);
  assign wrData = wrReq & sel_i[SEL_LOW] & (adr_i == REG_DATA);
  assign rdData = req & ~we_i & (adr_i == REG_DATA);
  assign wrStatus = wrReq & sel_i[SEL_LOW] & (adr_i == REG_STATUS);
  assign wrCtrl = wrReq & sel_i[SEL_LOW] & (adr_i == REG_CONTROL);

  // ==========================================================
  // Register state
  cfg_t cfg;
  cfg_t next_cfg;
  rate_t rate;
  rate_t next_rate;
  logic enabled;
  logic next_enabled;
  logic next_ack;
  logic [31:0] next_dat;

  // ==========================================================
  // Channel state
  state_t state;
  state_t next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shifter;
  logic [7:0] next_shifter;
  logic [7:0] txBuf;
  logic [7:0] next_txBuf;
  logic bufFull;
  logic next_bufFull;
  logic [7:0] rxData;
  logic [7:0] next_rxData;
  logic rxFull;
  logic next_rxFull;
  logic overrun;
  logic next_overrun;
  logic next_sck;
  logic next_so;
  logic next_soEn;
  logic next_irq;
  logic frameEnd;
  logic load;
  logic tick;

  csi_rate_divider rateGen (
    .clk(clk),
    .reset(reset),
    .run(state != ST_IDLE),
    .rate(rate),
    .tick(tick)
  );

  // ==========================================================
  // Register file and bus answer
  always_comb begin
    next_cfg = cfg;
    next_rate = rate;
    next_enabled = enabled;
    next_ack = req;
    next_dat = WORD_ZERO;
    if (wrMode) begin
      next_cfg = cfg_t'(dat_i[MODE_W-1:0]);
    end
    if (wrRateLow) begin
      next_rate[7:0] = dat_i[7:0];
    end
    if (wrRateHigh) begin
      next_rate[RATE_W-1:8] = dat_i[RATE_W-1:8];
    end
    if (wrCtrl && dat_i[CTRL_START]) begin
      next_enabled = 1'b1;
    end
    if (wrCtrl && dat_i[CTRL_STOP]) begin
      next_enabled = 1'b0;
    end
    if (req && !we_i) begin
      unique case (adr_i)
        REG_MODE: next_dat[MODE_W-1:0] = cfg;
        REG_CLKDIV: next_dat[RATE_W-1:0] = rate;
        REG_DATA: next_dat[7:0] = rxData;
        REG_STATUS: begin
          next_dat[ST_BUSY] = (state != ST_IDLE);
          next_dat[ST_BUF_FULL] = bufFull;
          next_dat[ST_RX_FULL] = rxFull;
          next_dat[ST_OVERRUN] = overrun;
        end
        REG_CONTROL: next_dat[CTRL_ENABLED] = enabled;
        default: next_dat = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= cfg_t'(MODE_RESET);
      rate <= rate_t'(RATE_RESET);
      enabled <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= WORD_ZERO;
    end else begin
      cfg <= next_cfg;
      rate <= next_rate;
      enabled <= next_enabled;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ==========================================================
  // Serial engine
  // The buffer loads into the shifter whenever it is full, the channel is enabled and
  // the engine is either idle or just finishing a frame, so frames follow back to back.
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shifter = shifter;
    next_txBuf = txBuf;
    next_bufFull = bufFull;
    next_rxData = rxData;
    next_rxFull = rxFull;
    next_overrun = overrun;
    next_so = serialOutPin;
    next_irq = 1'b0;
    frameEnd = 1'b0;
    load = 1'b0;
    if (rdData) begin
      next_rxFull = 1'b0;
    end
    if (wrStatus && dat_i[ST_OVERRUN]) begin
      next_overrun = 1'b0;
    end
    if (tick) begin
      unique case (state)
        ST_LEAD: begin
          next_state = ST_LOW;
          next_shifter = shiftIn(shifter, serialInPin, cfg);
          next_bitCnt = bitCnt + 4'h1;
        end
        ST_LOW: begin
          next_state = ST_HIGH;
          if (!cfg.data_phase_sel) begin
            next_shifter = shiftIn(shifter, serialInPin, cfg);
            next_bitCnt = bitCnt + 4'h1;
          end else if (bitCnt != frameLen(cfg)) begin
            next_so = headBit(shifter, cfg);
          end
        end
        ST_HIGH: begin
          if (bitCnt == frameLen(cfg)) begin
            frameEnd = 1'b1;
          end else begin
            next_state = ST_LOW;
            if (cfg.data_phase_sel) begin
              next_shifter = shiftIn(shifter, serialInPin, cfg);
              next_bitCnt = bitCnt + 4'h1;
            end else begin
              next_so = headBit(shifter, cfg);
            end
          end
        end
        ST_IDLE: begin
          next_state = state;
        end
      endcase
    end
    if (frameEnd) begin
      next_rxData = cfg.len7 ? {1'b0, shifter[6:0]} : shifter;
      next_rxFull = 1'b1;
      next_state = ST_IDLE;
      if (rxFull && !rdData) begin
        next_overrun = 1'b1;
      end
      if (!cfg.interrupt_timing_sel) begin
        next_irq = 1'b1;
      end
    end
    if (enabled && bufFull && (state == ST_IDLE || frameEnd)) begin
      load = 1'b1;
      next_bufFull = 1'b0;
      next_shifter = txBuf;
      next_bitCnt = 4'h0;
      next_so = headBit(txBuf, cfg);
      next_state = cfg.data_phase_sel ? ST_LEAD : ST_LOW;
      if (cfg.interrupt_timing_sel) begin
        next_irq = 1'b1;
      end
    end
    if (wrData) begin
      next_txBuf = dat_i[7:0];
      next_bufFull = 1'b1;
    end
    if (!enabled) begin
      next_state = ST_IDLE;
    end
    // Forward clocking idles high and pulses low; polarity set inverts it.
    next_sck = (next_state == ST_LOW) ? next_cfg.clock_polarity_sel
                                      : ~next_cfg.clock_polarity_sel;
    next_soEn = next_enabled & next_cfg.txRx;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shifter <= BYTE_ZERO;
      txBuf <= BYTE_ZERO;
      bufFull <= 1'b0;
      rxData <= BYTE_ZERO;
      rxFull <= 1'b0;
      overrun <= 1'b0;
      serialClockPin <= 1'b1;
      serialOutPin <= 1'b0;
      serialOutEnable <= 1'b0;
      channelInterrupt <= 1'b0;
    end else begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      shifter <= next_shifter;
      txBuf <= next_txBuf;
      bufFull <= next_bufFull;
      rxData <= next_rxData;
      rxFull <= next_rxFull;
      overrun <= next_overrun;
      serialClockPin <= next_sck;
      serialOutPin <= next_so;
      serialOutEnable <= next_soEn;
      channelInterrupt <= next_irq;
    end
  end

  // ==========================================================
  // Assertions
  property p_rx_only_quiet;
    @(posedge clk) disable iff (reset) !cfg.txRx |-> !serialOutEnable;
  endproperty
  a_rx_only_quiet: assert property (p_rx_only_quiet)
    else $error("output driven in receive-only mode");

  property p_idle_clock;
    @(posedge clk) disable iff (reset)
      state == ST_IDLE |-> serialClockPin != cfg.clock_polarity_sel;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("serial clock active while idle");

  property p_active_level;
    @(posedge clk) disable iff (reset)
      state == ST_LOW |-> serialClockPin == cfg.clock_polarity_sel;
  endproperty
  a_active_level: assert property (p_active_level)
    else $error("serial clock active level wrong");

  property p_rate_limit;
    @(posedge clk) disable iff (reset)
      ($past(state) != ST_IDLE && state != $past(state) && state != ST_IDLE) |-> $past(tick);
  endproperty
  a_rate_limit: assert property (p_rate_limit)
    else $error("serial clock phase changed without strobe");

  property p_frame_len;
    @(posedge clk) disable iff (reset) frameEnd |-> bitCnt == frameLen(cfg);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame ended with wrong bit count");

  property p_overrun;
    @(posedge clk) disable iff (reset) frameEnd && rxFull && !rdData |=> overrun;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_overrun_cause;
    @(posedge clk) disable iff (reset) $rose(overrun) |-> $past(frameEnd);
  endproperty
  a_overrun_cause: assert property (p_overrun_cause)
    else $error("overrun set without frame end");

  property p_end_irq;
    @(posedge clk) disable iff (reset)
      frameEnd && !cfg.interrupt_timing_sel |=> channelInterrupt;
  endproperty
  a_end_irq: assert property (p_end_irq)
    else $error("missing transfer-end interrupt");

  property p_empty_irq;
    @(posedge clk) disable iff (reset)
      load && cfg.interrupt_timing_sel |=> channelInterrupt ##1 !channelInterrupt;
  endproperty
  a_empty_irq: assert property (p_empty_irq)
    else $error("buffer-empty interrupt wrong");

  property p_overwrite;
    @(posedge clk) disable iff (reset)
      wrData |=> bufFull && txBuf == $past(dat_i[7:0]);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("transmit buffer not replaced");

  property p_phase_start;
    @(posedge clk) disable iff (reset)
      load && enabled |=> state == ($past(cfg.data_phase_sel) ? ST_LEAD : ST_LOW);
  endproperty
  a_phase_start: assert property (p_phase_start)
    else $error("frame started in wrong phase");

  c_frame_end: cover property (@(posedge clk) disable iff (reset) frameEnd);
  c_back_to_back: cover property (@(posedge clk) disable iff (reset) frameEnd && load);
  c_overrun: cover property (@(posedge clk) disable iff (reset) $rose(overrun));
  c_lead: cover property (@(posedge clk) disable iff (reset) state == ST_LEAD);

endmodule

/* tb/csi_slave_model.sv */
// Behavioural slave device on the far side of the three-wire serial link.
`timescale 1ns/10ps

module csi_slave_model
  import csi_chan_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins seen from the slave
  input wire logic serialClockPin,
  input wire logic serialOutPin,
  output logic serialInPin,
  // Frame setup from the bench
  input wire cfg_t cfg,
  input wire logic load,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  // ==========================================================
  // Edge classification
  logic prevSck;
  logic [7:0] shTx;
  int sampled;
  int len;
  logic leadEdge;
  logic sampleEdge;

  assign len = cfg.len7 ? 7 : 8;
  assign leadEdge = (prevSck === ~cfg.clock_polarity_sel);
  // Phase zero captures on the return to rest, phase one on the departure from rest.
  assign sampleEdge = (leadEdge === cfg.data_phase_sel);

  function automatic logic bitAt(input int i);
    bitAt = cfg.lsbFirst ? shTx[i] : shTx[len-1-i];
  endfunction

  // ==========================================================
  // Shifter
  // The model changes its data only half a period away from the capture edge, as a real
  // slave would; once the frame is done it flips the line so stale data cannot pass.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prevSck <= 1'b1;
      serialInPin <= 1'b0;
      sampled <= 0;
      rxByte <= 8'h00;
      shTx <= 8'h00;
    end else begin
      prevSck <= serialClockPin;
      if (load) begin
        shTx <= txByte;
        sampled <= 0;
        rxByte <= 8'h00;
        serialInPin <= cfg.lsbFirst ? txByte[0] : txByte[len-1];
      end else if (serialClockPin !== prevSck) begin
        if (sampleEdge) begin
          if (sampled < len) begin
            if (cfg.lsbFirst) begin
              rxByte[sampled] <= serialOutPin;
            end else begin
              rxByte[len-1-sampled] <= serialOutPin;
            end
          end
          sampled <= sampled + 1;
        end else if (cfg.data_phase_sel || sampled > 0) begin
          serialInPin <= (sampled < len) ? bitAt(sampled) : ~serialInPin;
        end
      end
    end
  end
endmodule

/* tb/csi_master_receive_duplex_tb.sv */
// Self-checking bench of the serial channel with a slave model on its pins.
`timescale 1ns/10ps

module csi_master_receive_duplex_tb
  import csi_chan_pkg::*;
;
  typedef struct {
    logic [5:0] mode;
    logic [10:0] div;
    logic [7:0] tx;
    logic [7:0] sl;
    int h;
    bit chkRx;
  } row_t;

  logic clk, reset, cyc, stb, we, ack, serialClockPin, serialInPin, serialOutPin;
  logic serialOutEnable, channelInterrupt, load;
  logic [2:0] adr;
  logic [31:0] datI, datO, q;
  logic [7:0] modelTx, modelRx, mask;
  cfg_t modelCfg, c;
  int numErrors, nChecks, cycles, h, n, i;
  row_t r;
  row_t rows[7] = '{
    '{6'h02, 11'h010, 8'hA5, 8'h5A, 2, 1}, '{6'h0E, 11'h021, 8'hC3, 8'h81, 6, 1},
    '{6'h12, 11'h000, 8'h1E, 8'h77, 1, 0}, '{6'h26, 11'h010, 8'hD5, 8'h4B, 2, 1},
    '{6'h3A, 11'h010, 8'h6C, 8'hF1, 2, 1}, '{6'h00, 11'h010, 8'h00, 8'hB4, 2, 1},
    '{6'h2C, 11'h010, 8'h00, 8'h39, 2, 1}};

  csi_master_receive_duplex dut_u (.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .serialClockPin(serialClockPin), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .serialOutEnable(serialOutEnable),
    .channelInterrupt(channelInterrupt));

  csi_slave_model slave_u (.clk(clk), .reset(reset), .serialClockPin(serialClockPin),
    .serialOutPin(serialOutPin), .serialInPin(serialInPin), .cfg(modelCfg),
    .load(load), .txByte(modelTx), .rxByte(modelRx));

  // ==========================================================
  // Report and comparisons
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmpBit(input string nm, input logic e, input logic g);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ==========================================================
  // Bus, interrupt and link helpers
  task automatic wbCycle(input logic w, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    cmpWord("bus latency", 32'h2, k);
  endtask

  task automatic waitIrq(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (channelInterrupt !== 1'b1 && cnt < 3000);
    cmpBit("interrupt seen", 1'b1, cnt < 3000);
  endtask

  // The first two intervals hold start-up and a possibly stretched half, so the third is timed.
  task automatic measHalf(output int hh);
    logic p;
    for (int j = 0; j < 3; j++) begin
      p = serialClockPin;
      hh = 0;
      do begin
        @(posedge clk);
        hh++;
      end while (serialClockPin === p && hh < 600);
    end
  endtask

  task automatic loadModel(input cfg_t cf, input logic [7:0] b);
    @(posedge clk);
    modelCfg <= cf;
    modelTx <= b;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      tallyAndFinish();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {cyc, stb, we, load, adr, datI, modelTx, numErrors, nChecks, cycles} = '0;
    modelCfg = cfg_t'(6'h00);
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    cmpBit("rest clock", 1'b1, serialClockPin);
    cmpBit("rest enable", 1'b0, serialOutEnable);
    wbCycle(1'b1, 3'h6, 32'hFFFF_FFFF);
    for (i = 0; i < 8; i++) begin
      wbCycle(1'b0, i[2:0], 32'h0);
      cmpWord("reset read", 32'h0, q);
    end
    wbCycle(1'b1, REG_CONTROL, 32'h1);
    for (i = 0; i < 7; i++) begin
      r = rows[i];
      c = cfg_t'(r.mode);
      mask = c.len7 ? 8'h7F : 8'hFF;
      wbCycle(1'b1, REG_MODE, {26'h0, r.mode});
      wbCycle(1'b1, REG_CLKDIV, {21'h0, r.div});
      @(posedge clk);
      cmpBit("idle clock", ~c.clock_polarity_sel, serialClockPin);
      loadModel(c, r.sl);
      wbCycle(1'b1, REG_DATA, {24'h0, r.tx});
      measHalf(h);
      cmpWord("half period", r.h, h);
      cmpBit("output enable", c.txRx, serialOutEnable);
      waitIrq(n);
      @(posedge clk);
      cmpBit("clock at rest", ~c.clock_polarity_sel, serialClockPin);
      if (c.txRx) cmpWord("sent bits", {24'h0, r.tx & mask}, {24'h0, modelRx});
      wbCycle(1'b0, REG_DATA, 32'h0);
      if (r.chkRx) cmpWord("received", {24'h0, r.sl & mask}, q);
    end
    // Held transmit data is replaced while the channel is stopped.
    wbCycle(1'b1, REG_CONTROL, 32'h2);
    wbCycle(1'b1, REG_MODE, 32'h02);
    wbCycle(1'b1, REG_CLKDIV, 32'h10);
    wbCycle(1'b1, REG_DATA, 32'hA5);
    wbCycle(1'b0, REG_STATUS, 32'h0);
    cmpWord("held status", 32'h2, q);
    wbCycle(1'b1, REG_DATA, 32'h3C);
    loadModel(cfg_t'(6'h02), 8'h99);
    wbCycle(1'b1, REG_CONTROL, 32'h1);
    waitIrq(n);
    cmpWord("replaced data", 32'h3C, {24'h0, modelRx});
    wbCycle(1'b0, REG_DATA, 32'h0);
    // Two receive frames without reading the first one.
    wbCycle(1'b1, REG_MODE, 32'h00);
    for (i = 0; i < 2; i++) begin
      loadModel(cfg_t'(6'h00), 8'h70 + i[7:0]);
      wbCycle(1'b1, REG_DATA, 32'h0);
      waitIrq(n);
    end
    wbCycle(1'b0, REG_STATUS, 32'h0);
    cmpWord("overrun status", 32'hC, q);
    wbCycle(1'b1, REG_STATUS, 32'h8);
    wbCycle(1'b0, REG_STATUS, 32'h0);
    cmpWord("overrun cleared", 32'h4, q);
    wbCycle(1'b0, REG_DATA, 32'h0);
    cmpWord("latest frame", 32'h71, q);
    // Buffer-empty interrupt, then a switch to frame-end timing in mid-frame.
    wbCycle(1'b1, REG_MODE, 32'h03);
    loadModel(cfg_t'(6'h03), 8'h00);
    wbCycle(1'b1, REG_DATA, 32'h96);
    waitIrq(n);
    cmpBit("empty interrupt early", 1'b1, n <= 2);
    wbCycle(1'b0, REG_STATUS, 32'h0);
    cmpWord("busy status", 32'h1, q);
    wbCycle(1'b1, REG_MODE, 32'h02);
    waitIrq(n);
    cmpBit("end interrupt late", 1'b1, n > 8);
    cmpWord("undisturbed frame", 32'h96, {24'h0, modelRx});
    // A reset in mid-run is followed by a full set-up, never by a resume.
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmpBit("restart clock", 1'b1, serialClockPin);
    cmpBit("restart interrupt", 1'b0, channelInterrupt);
    @(posedge clk);
    cmpBit("restart enable", 1'b0, serialOutEnable);
    wbCycle(1'b0, REG_MODE, 32'h0);
    cmpWord("restart mode", 32'h0, q);
    wbCycle(1'b1, REG_CLKDIV, 32'h10);
    wbCycle(1'b1, REG_CONTROL, 32'h1);
    loadModel(cfg_t'(6'h00), 8'h5C);
    wbCycle(1'b1, REG_DATA, 32'h0);
    waitIrq(n);
    wbCycle(1'b0, REG_DATA, 32'h0);
    cmpWord("restart frame", 32'h5C, q);
    tallyAndFinish();
  end
endmodule
